//--- core/exec_unit.sv
// Purpose: execute stage for a subset of an 8-bit risc instruction set
// Assumes: decoder, data memory, stack and clock gate sit outside
// Notes:   one request per free cycle; pc-changing ops add a dummy cycle
`timescale 1ns/10ps

// Behaviour
// RL1: daa adds 6 to low nibble if needed
// RL2: daa adds 6 to high nibble if needed
// RL3: daa writes memory, only carry changes
// RL4: decrement, memory or acc, zero flag only
// RL5: increment, memory or acc, zero flag only
// RL6: power-down stops execution, gates clock, retains state
// RL7: power-down clears watchdog, sets pdf, clears timeout
// RL8: jump loads pc, two cycles, no flags
// RL9: moves copy bytes, no flags change
// RL10: no-operation changes nothing, advances
// RL11: or to acc or memory, zero flag only
// RL12: return pops pc, optional immediate to acc
// RL13: interrupt return pops pc, sets enable
// RL14: pending interrupt served before main program
// RL15: rotate left, bit7 into bit0, no flags
// RL16: rotate left through carry
// RL17: rotate right, bit0 into bit7, no flags
// RL18: rotate right through carry
// RL19: subtract memory and inverted carry from acc
// RL20: carry clear if negative, else set
// RL21: subtract updates ov z ac c sc cz
// RL22: zero flag set when result is zero
module exec_unit (
	input  wire logic                  core_clk,
	input  wire logic                  arst_n,
	input  wire exec_pkg::exec_req_type exec_req,
	input  wire logic                  irq_pending,
	input  wire logic                  wdt_timeout,
	input  wire logic [3:0]            reg_addr,
	input  wire logic [7:0]            reg_wdata,
	input  wire logic                  reg_wr,
	input  wire logic                  reg_rd,
	output logic [7:0]                 reg_rdata,
	output logic                       busy,
	output logic                       instr_done,
	output logic [7:0]                 acc,
	output exec_pkg::flags_type        flags,
	output logic                       mem_wr,
	output logic [7:0]                 mem_wdata,
	output logic                       pc_load,
	output logic [11:0]                pc_target,
	output logic                       stack_pop,
	output logic                       irq_service,
	output logic                       wdt_clear,
	output logic                       clk_run,
	output logic                       power_down_flag,
	output logic                       watchdog_timeout_flag,
	output logic                       global_interrupt_enable
);

	// ****************************************
	// state and registers
	// ****************************************
	typedef enum logic [1:0] {exec_st, dummy_st, halted_st} state_type;

	state_type           state_reg;     // sequencing state
	state_type           state_next;    // its next value
	logic [7:0]          acc_reg;       // accumulator
	logic [7:0]          acc_next;
	exec_pkg::flags_type flags_reg;     // status flags
	exec_pkg::flags_type flags_next;
	logic                mem_wr_reg;    // one-cycle memory write
	logic                mem_wr_next;
	logic [7:0]          mem_wdata_reg; // byte to memory
	logic [7:0]          mem_wdata_next;
	logic                pc_load_reg;   // one-cycle pc load
	logic                pop_reg;       // one-cycle stack pop
	logic [11:0]         pc_target_reg; // jump address
	logic                irq_svc_reg;   // serve pending interrupt
	logic                done_reg;      // instruction complete pulse
	logic                busy_reg;      // no request taken
	logic                wdt_clr_reg;   // watchdog and prescaler clear
	logic                clk_run_reg;   // clock gate enable
	logic                pdf_reg;       // power_down_flag
	logic                to_reg;        // watchdog_timeout_flag
	logic                gie_reg;       // global_interrupt_enable
	logic [7:0]          rdata_reg;     // read data, one cycle late

	logic                take;          // request accepted this edge
	logic                wake;          // software wake strobe
	logic [7:0]          operand;       // memory or immediate operand
	logic [8:0]          sub_wide;      // subtract with borrow out
	logic [4:0]          sub_low;       // low nibble borrow chain
	logic [7:0]          bcd_adj;       // 00, 06, 60 or 66
	logic [8:0]          bcd_wide;      // adjusted sum with carry out

	assign take = exec_req.valid && (state_reg == exec_st);
	assign wake = reg_wr && (reg_addr == exec_pkg::CTRL_ADDR)
		&& reg_wdata[exec_pkg::CTRL_WAKE_BIT];
	assign operand = exec_req.use_imm ? exec_req.imm : exec_req.mem_data;

	// ****************************************
	// arithmetic helpers
	// ****************************************
	// borrow is the inverted carry, so c=1 means no borrow in
	assign sub_wide = {1'b0, acc_reg} - {1'b0, exec_req.mem_data}
		- {8'h00, ~flags_reg.c};                                  // [RL19]
	assign sub_low = {1'b0, acc_reg[3:0]} - {1'b0, exec_req.mem_data[3:0]}
		- {4'h0, ~flags_reg.c};
	// both nibbles judged on the original accumulator
	assign bcd_adj[3:0] = ((acc_reg[3:0] > exec_pkg::NIBBLE_LIMIT)
		|| flags_reg.hc) ? exec_pkg::BCD_ADJUST : 4'h0;           // [RL1]
	assign bcd_adj[7:4] = ((acc_reg[7:4] > exec_pkg::NIBBLE_LIMIT)
		|| flags_reg.c) ? exec_pkg::BCD_ADJUST : 4'h0;            // [RL2]
	assign bcd_wide = {1'b0, acc_reg} + {1'b0, bcd_adj};

	// ****************************************
	// datapath next values
	// ****************************************
	// defaults hold everything, so unnamed effects never happen
	always_comb begin
		acc_next = acc_reg;
		flags_next = flags_reg;
		mem_wr_next = 1'b0;
		mem_wdata_next = mem_wdata_reg;
		case (exec_req.op)
			exec_pkg::decimal_adjust_op: begin
				mem_wr_next = 1'b1;                                   // [RL3]
				mem_wdata_next = bcd_wide[7:0];
				flags_next.c = flags_reg.c | bcd_wide[8];             // [RL3]
			end
			exec_pkg::decrement_op: begin
				mem_wr_next = 1'b1;
				mem_wdata_next = exec_req.mem_data - exec_pkg::ONE;   // [RL4]
				flags_next.z = (mem_wdata_next == 8'h00);             // [RL22]
			end
			exec_pkg::decrement_to_acc_op: begin
				acc_next = exec_req.mem_data - exec_pkg::ONE;         // [RL4]
				flags_next.z = (acc_next == 8'h00);                   // [RL22]
			end
			exec_pkg::increment_op: begin
				mem_wr_next = 1'b1;
				mem_wdata_next = exec_req.mem_data + exec_pkg::ONE;   // [RL5]
				flags_next.z = (mem_wdata_next == 8'h00);             // [RL22]
			end
			exec_pkg::increment_to_acc_op: begin
				acc_next = exec_req.mem_data + exec_pkg::ONE;         // [RL5]
				flags_next.z = (acc_next == 8'h00);                   // [RL22]
			end
			exec_pkg::move_mem_to_acc_op: begin
				acc_next = exec_req.mem_data;                         // [RL9]
			end
			exec_pkg::move_imm_to_acc_op: begin
				acc_next = exec_req.imm;                              // [RL9]
			end
			exec_pkg::move_acc_to_mem_op: begin
				mem_wr_next = 1'b1;                                   // [RL9]
				mem_wdata_next = acc_reg;
			end
			exec_pkg::or_acc_op: begin
				acc_next = acc_reg | operand;                         // [RL11]
				flags_next.z = (acc_next == 8'h00);                   // [RL22]
			end
			exec_pkg::or_to_memory_op: begin
				mem_wr_next = 1'b1;
				mem_wdata_next = acc_reg | exec_req.mem_data;         // [RL11]
				flags_next.z = (mem_wdata_next == 8'h00);             // [RL22]
			end
			exec_pkg::subroutine_return_imm_op: begin
				acc_next = exec_req.imm;                              // [RL12]
			end
			exec_pkg::rotate_left_op: begin
				mem_wr_next = 1'b1;
				mem_wdata_next = {exec_req.mem_data[6:0],
					exec_req.mem_data[7]};                            // [RL15]
			end
			exec_pkg::rotate_left_to_acc_op: begin
				acc_next = {exec_req.mem_data[6:0],
					exec_req.mem_data[7]};                            // [RL15]
			end
			exec_pkg::rotate_left_carry_op: begin
				mem_wr_next = 1'b1;
				mem_wdata_next = {exec_req.mem_data[6:0], flags_reg.c};
				flags_next.c = exec_req.mem_data[7];                  // [RL16]
			end
			exec_pkg::rotate_left_carry_to_acc_op: begin
				acc_next = {exec_req.mem_data[6:0], flags_reg.c};
				flags_next.c = exec_req.mem_data[7];                  // [RL16]
			end
			exec_pkg::rotate_right_op: begin
				mem_wr_next = 1'b1;
				mem_wdata_next = {exec_req.mem_data[0],
					exec_req.mem_data[7:1]};                          // [RL17]
			end
			exec_pkg::rotate_right_to_acc_op: begin
				acc_next = {exec_req.mem_data[0],
					exec_req.mem_data[7:1]};                          // [RL17]
			end
			exec_pkg::rotate_right_carry_op: begin
				mem_wr_next = 1'b1;
				mem_wdata_next = {flags_reg.c, exec_req.mem_data[7:1]};
				flags_next.c = exec_req.mem_data[0];                  // [RL18]
			end
			exec_pkg::rotate_right_carry_to_acc_op: begin
				acc_next = {flags_reg.c, exec_req.mem_data[7:1]};
				flags_next.c = exec_req.mem_data[0];                  // [RL18]
			end
			exec_pkg::subtract_borrow_op: begin
				acc_next = sub_wide[7:0];                             // [RL19]
				flags_next.c = ~sub_wide[8];                          // [RL20]
				flags_next.hc = ~sub_low[4];                          // [RL21]
				flags_next.z = (sub_wide[7:0] == 8'h00);              // [RL22]
				flags_next.vf = (acc_reg[7] ^ exec_req.mem_data[7])
					& (acc_reg[7] ^ sub_wide[7]);                     // [RL21]
				flags_next.lt = flags_next.vf ^ sub_wide[7];          // [RL21]
				// zero across a chain of multi-byte subtracts
				flags_next.zc = flags_next.z & flags_reg.zc;          // [RL21]
			end
			// nop, jump, plain and interrupt returns, power-down leave data alone
			default: begin
				acc_next = acc_reg;                                   // [RL10]
			end
		endcase
	end

	// ****************************************
	// sequencing
	// ****************************************
	// pc-changing ops park one dummy cycle while the new address fetches
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			exec_st: begin
				if (take && ((exec_req.op == exec_pkg::jump_op)
					|| (exec_req.op == exec_pkg::subroutine_return_op)
					|| (exec_req.op == exec_pkg::subroutine_return_imm_op)
					|| (exec_req.op == exec_pkg::interrupt_return_op))) begin
					state_next = dummy_st;                            // [RL8]
				end else if (take
					&& (exec_req.op == exec_pkg::power_down_op)) begin
					state_next = halted_st;                           // [RL6]
				end
			end
			dummy_st: begin
				state_next = exec_st;
			end
			halted_st: begin
				if (irq_pending || wake) begin
					state_next = exec_st;
				end
			end
			default: begin
				state_next = exec_st;
			end
		endcase
	end

	// state, busy and completion pulse
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			state_reg <= exec_st;
			busy_reg <= 1'b0;
			done_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			busy_reg <= (state_next != exec_st);
			// straight ops finish at once, pc ops after the dummy
			done_reg <= (take && (state_next == exec_st))
				|| (state_reg == dummy_st);                            // [RL10]
		end
	end

	// accumulator, flags and memory write port
	// halted state takes no request, so all contents are retained
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			acc_reg <= exec_pkg::ACC_RESET;
			flags_reg <= exec_pkg::FLAGS_RESET;
			mem_wr_reg <= 1'b0;
			mem_wdata_reg <= 8'h00;
		end else begin
			mem_wr_reg <= take && mem_wr_next;
			if (take) begin
				acc_reg <= acc_next;
				flags_reg <= flags_next;
				mem_wdata_reg <= mem_wdata_next;
			end
		end
	end

	// program counter and stack requests
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			pc_load_reg <= 1'b0;
			pop_reg <= 1'b0;
			pc_target_reg <= '0;
			irq_svc_reg <= 1'b0;
		end else begin
			pc_load_reg <= take && (exec_req.op == exec_pkg::jump_op);
			pop_reg <= take
				&& ((exec_req.op == exec_pkg::subroutine_return_op)
				|| (exec_req.op == exec_pkg::subroutine_return_imm_op)
				|| (exec_req.op == exec_pkg::interrupt_return_op)); // [RL12]
			// pending request is vectored before the main program resumes
			irq_svc_reg <= take && irq_pending
				&& (exec_req.op == exec_pkg::interrupt_return_op);  // [RL14]
			if (take && (exec_req.op == exec_pkg::jump_op)) begin
				pc_target_reg <= exec_req.target;                    // [RL8]
			end
		end
	end

	// power-down and watchdog flags
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			wdt_clr_reg <= 1'b0;
			clk_run_reg <= 1'b1;
			pdf_reg <= 1'b0;
			to_reg <= 1'b0;
		end else begin
			wdt_clr_reg <= take && (exec_req.op == exec_pkg::power_down_op);
			if (take && (exec_req.op == exec_pkg::power_down_op)) begin
				clk_run_reg <= 1'b0;                                 // [RL6]
				pdf_reg <= 1'b1;                                     // [RL7]
			end else if (state_next == exec_st) begin
				clk_run_reg <= 1'b1;
			end
			// a timeout in the clearing cycle is kept
			if (wdt_timeout) begin
				to_reg <= 1'b1;
			end else if (take
				&& (exec_req.op == exec_pkg::power_down_op)) begin
				to_reg <= 1'b0;                                      // [RL7]
			end
		end
	end

	// ****************************************
	// register port
	// ****************************************
	// interrupt return wins over a software write in the same cycle
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			gie_reg <= 1'b0;
		end else if (take
			&& (exec_req.op == exec_pkg::interrupt_return_op)) begin
			gie_reg <= 1'b1;                                         // [RL13]
		end else if (reg_wr && (reg_addr == exec_pkg::CTRL_ADDR)) begin
			gie_reg <= reg_wdata[exec_pkg::CTRL_GIE_BIT];
		end
	end

	// read data valid only in the cycle after the strobe
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			rdata_reg <= 8'h00;
		end else if (reg_rd) begin
			case (reg_addr)
				exec_pkg::CTRL_ADDR: begin
					rdata_reg <= {6'h00, gie_reg, 1'b0};
				end
				exec_pkg::STATUS_ADDR: begin
					rdata_reg <= {to_reg, pdf_reg, flags_reg};
				end
				exec_pkg::ACC_ADDR: begin
					rdata_reg <= acc_reg;
				end
				default: begin
					rdata_reg <= 8'h00;
				end
			endcase
		end else begin
			rdata_reg <= 8'h00;
		end
	end

	// ****************************************
	// outputs
	// ****************************************
	assign reg_rdata = rdata_reg;
	assign busy = busy_reg;
	assign instr_done = done_reg;
	assign acc = acc_reg;
	assign flags = flags_reg;
	assign mem_wr = mem_wr_reg;
	assign mem_wdata = mem_wdata_reg;
	assign pc_load = pc_load_reg;
	assign pc_target = pc_target_reg;
	assign stack_pop = pop_reg;
	assign irq_service = irq_svc_reg;
	assign wdt_clear = wdt_clr_reg;
	assign clk_run = clk_run_reg;
	assign power_down_flag = pdf_reg;
	assign watchdog_timeout_flag = to_reg;
	assign global_interrupt_enable = gie_reg;

	// ****************************************
	// assertions
	// ****************************************
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!arst_n);

	a_bcd_low_adjust : // [RL1]
	assert property (take && exec_req.op == exec_pkg::decimal_adjust_op
		&& acc_reg[3:0] > 4'h9 && acc_reg[7:4] < 4'h9 && !flags_reg.c
		|=> mem_wdata_reg == $past(acc_reg) + 8'h06)
		else $error("daa low nibble not adjusted by 6");
	a_bcd_high_adjust : // [RL2]
	assert property (take && exec_req.op == exec_pkg::decimal_adjust_op
		&& acc_reg[7:4] > 4'h9 && acc_reg[3:0] <= 4'h9 && !flags_reg.hc
		|=> mem_wdata_reg == $past(acc_reg) + 8'h60 && flags_reg.c)
		else $error("daa high nibble not adjusted by 6");
	a_bcd_flags_kept : // [RL3]
	assert property (take && exec_req.op == exec_pkg::decimal_adjust_op
		|=> mem_wr_reg && $stable(acc_reg) && $stable(flags_reg.z)
		&& $stable(flags_reg.vf) && $stable(flags_reg.zc))
		else $error("daa touched more than carry or missed write");
	a_decr_mem_zero : // [RL4]
	assert property (take && exec_req.op == exec_pkg::decrement_op
		|=> mem_wr_reg && mem_wdata_reg == $past(exec_req.mem_data) - 8'h01
		&& flags_reg.z == (mem_wdata_reg == 8'h00) && $stable(acc_reg))
		else $error("decrement to memory wrong");
	a_inc_to_acc : // [RL5]
	assert property (take && exec_req.op == exec_pkg::increment_to_acc_op
		|=> !mem_wr_reg && acc_reg == $past(exec_req.mem_data) + 8'h01
		&& $stable(flags_reg.c))
		else $error("increment to accumulator wrong");
	a_halt_entry : // [RL7]
	assert property (take && exec_req.op == exec_pkg::power_down_op
		&& !wdt_timeout |=> !clk_run_reg && wdt_clr_reg && pdf_reg
		&& !to_reg && busy_reg)
		else $error("power-down entry effects missing");
	a_jump_two_cycles : // [RL8]
	assert property (take && exec_req.op == exec_pkg::jump_op
		|=> pc_load_reg && busy_reg && !done_reg
		&& pc_target_reg == $past(exec_req.target) ##1 done_reg)
		else $error("jump did not load pc over two cycles");
	a_noop_quiet : // [RL10]
	assert property (take && exec_req.op == exec_pkg::no_operation
		|=> done_reg && !mem_wr_reg && $stable(acc_reg) && $stable(flags_reg))
		else $error("no-operation changed state");
	a_iret_pending : // [RL14]
	assert property (take && exec_req.op == exec_pkg::interrupt_return_op
		&& irq_pending |=> stack_pop && gie_reg && irq_svc_reg)
		else $error("pending interrupt not served on return");
	a_rotc_carry : // [RL16]
	assert property (take && exec_req.op == exec_pkg::rotate_left_carry_op
		|=> flags_reg.c == $past(exec_req.mem_data[7])
		&& mem_wdata_reg[0] == $past(flags_reg.c))
		else $error("rotate left through carry wrong");
	a_sub_carry : // [RL20]
	assert property (take && exec_req.op == exec_pkg::subtract_borrow_op
		|=> flags_reg.c == !$past(sub_wide[8])
		&& acc_reg == $past(sub_wide[7:0]))
		else $error("subtract with borrow carry wrong");

	c_jump_done : cover property (take && exec_req.op == exec_pkg::jump_op
		##2 done_reg);
	c_halt_wake : cover property (state_reg == halted_st ##1
		state_reg == exec_st);
	c_iret_irq : cover property (irq_svc_reg);

endmodule // exec_unit

//--- shared/exec_pkg.sv
// Purpose: shared types and constants of the execute subset datapath
// Assumes: 8-bit data path, 12-bit program counter
// Notes:   offsets are byte addresses on the plain register port
package exec_pkg;

	// ****************************************
	// widths and arithmetic constants
	// ****************************************
	localparam int DATA_W = 8;                   // data byte width
	localparam int PC_W   = 12;                  // program address width
	localparam logic [3:0] NIBBLE_LIMIT = 4'h9;  // largest bcd digit
	localparam logic [3:0] BCD_ADJUST   = 4'h6;  // per-nibble correction
	localparam logic [7:0] ONE          = 8'h01; // step of inc and dec
	localparam logic [7:0] ACC_RESET    = 8'h00; // accumulator after reset

	// ****************************************
	// register port map
	// ****************************************
	localparam logic [3:0] CTRL_ADDR   = 4'h0;   // wake and interrupt enable
	localparam logic [3:0] STATUS_ADDR = 4'h4;   // flags, read only
	localparam logic [3:0] ACC_ADDR    = 4'h8;   // accumulator, read only
	localparam int CTRL_WAKE_BIT = 0;            // write 1: leave power-down
	localparam int CTRL_GIE_BIT  = 1;            // global interrupt enable

	// ****************************************
	// operations and carriers
	// ****************************************
	typedef enum logic [4:0] {
		no_operation, decimal_adjust_op, decrement_op, decrement_to_acc_op,
		increment_op, increment_to_acc_op, power_down_op, jump_op,
		move_mem_to_acc_op, move_imm_to_acc_op, move_acc_to_mem_op,
		or_acc_op, or_to_memory_op, subroutine_return_op,
		subroutine_return_imm_op, interrupt_return_op,
		rotate_left_op, rotate_left_to_acc_op, rotate_left_carry_op,
		rotate_left_carry_to_acc_op, rotate_right_op, rotate_right_to_acc_op,
		rotate_right_carry_op, rotate_right_carry_to_acc_op,
		subtract_borrow_op
	} op_code_type;

	// one decoded instruction from the decoder
	typedef struct packed {
		logic              valid;    // request strobe
		op_code_type       op;       // operation
		logic              use_imm;  // or_acc_op: immediate instead of [m]
		logic [DATA_W-1:0] mem_data; // addressed data byte
		logic [DATA_W-1:0] imm;      // immediate value
		logic [PC_W-1:0]   target;   // jump address
	} exec_req_type;

	// status flags, status register bits 5..0
	typedef struct packed {
		logic zc;  // carry_zero_flag
		logic lt;  // signed_compare_flag
		logic vf;  // overflow_flag
		logic hc;  // aux_carry_flag
		logic c;   // carry
		logic z;   // zero
	} flags_type;

	localparam flags_type FLAGS_RESET = '0;

endpackage

//--- tb/mem_stack_model.sv
// Purpose: data memory and stack side facing the execute unit
// Assumes: one clock, writes and pops are one-cycle pulses
// Notes:   keeps the last byte written and a count of pops
`timescale 1ns/10ps
module mem_stack_model (
	input  wire logic       core_clk,
	input  wire logic       arst_n,
	input  wire logic       mem_wr,
	input  wire logic [7:0] mem_wdata,
	input  wire logic       stack_pop,
	output logic [7:0]      mem_byte,
	output logic [3:0]      pops
);
	// ram and stack pointer only move on a strobe, like the real ones
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			mem_byte <= 8'h00;
			pops     <= 4'h0;
		end else begin
			if (mem_wr)
				mem_byte <= mem_wdata;
			if (stack_pop)
				pops <= pops + 4'h1;
		end
	end
endmodule // mem_stack_model

//--- tb/tb_top.sv
// Purpose: self-checking bench for the execute unit
// Assumes: results registered at the taking edge, sampled just after it
// Notes:   plain ops are table rows, control ops are hand tests
`timescale 1ns/10ps
module tb_top;
	typedef struct {
		exec_pkg::op_code_type op; // operation
		logic [7:0]            m;  // memory byte, also immediate
		logic [7:0]            a;  // expected accumulator
		logic [3:0]            f;  // use_imm, carry, zero, write
		logic [7:0]            d;  // expected write data
	} row_type;
	logic                   core_clk, arst_n, irq_pending, wdt_timeout;
	logic                   reg_wr, reg_rd, busy, instr_done, mem_wr;
	logic                   pc_load, stack_pop, irq_service, wdt_clear;
	logic                   clk_run, power_down_flag, watchdog_timeout_flag;
	logic                   global_interrupt_enable;
	logic [3:0]             reg_addr, pops;
	logic [7:0]             reg_wdata, reg_rdata, acc, mem_wdata, mem_byte;
	logic [11:0]            pc_target;
	exec_pkg::exec_req_type exec_req;
	exec_pkg::flags_type    flags;
	row_type                rows[$];
	int                     n_fail, tests_run;

	exec_unit exec_unit_i (.core_clk(core_clk), .arst_n(arst_n),
		.exec_req(exec_req), .irq_pending(irq_pending),
		.wdt_timeout(wdt_timeout), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .busy(busy), .instr_done(instr_done),
		.acc(acc), .flags(flags), .mem_wr(mem_wr), .mem_wdata(mem_wdata),
		.pc_load(pc_load), .pc_target(pc_target), .stack_pop(stack_pop),
		.irq_service(irq_service), .wdt_clear(wdt_clear),
		.clk_run(clk_run), .power_down_flag(power_down_flag),
		.watchdog_timeout_flag(watchdog_timeout_flag),
		.global_interrupt_enable(global_interrupt_enable));
	mem_stack_model mem_stack_model_i (.core_clk(core_clk), .arst_n(arst_n),
		.mem_wr(mem_wr), .mem_wdata(mem_wdata), .stack_pop(stack_pop),
		.mem_byte(mem_byte), .pops(pops));

	// ****************************************
	// shared tasks
	// ****************************************
	// case equality, so an unknown never passes
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		tests_run++;
		if (got !== exp) begin
			n_fail++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// one request, taken at the second edge, results sampled after it
	task automatic issue(input exec_pkg::op_code_type op,
		input logic [7:0] m, input logic u);
		@(posedge core_clk);
		exec_req <= '{1'b1, op, u, m, m, 12'h5a3};
		@(posedge core_clk);
		exec_req.valid <= 1'b0;
		#1;
	endtask
	// register access; read data stands only in the cycle after
	task automatic rw(input logic wr, input logic [3:0] a,
		input logic [7:0] d);
		@(posedge core_clk);
		reg_wr <= wr;
		reg_rd <= !wr;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge core_clk);
		reg_wr <= 1'b0;
		reg_rd <= 1'b0;
		#1;
	endtask
	function automatic void r(exec_pkg::op_code_type op, logic [7:0] m,
		logic [7:0] a, logic [3:0] f, logic [7:0] d);
		rows.push_back('{op, m, a, f, d});
	endfunction
	task automatic end_of_test;
		$display("tests_run=%0d n_fail=%0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	// ****************************************
	// clock, watchdog, sequence
	// ****************************************
	initial begin
		core_clk = 1'b0;
		forever #4 core_clk = ~core_clk;
	end
	// whole run is under a hundred cycles; this is ample
	initial begin
		#20000;
		n_fail++;
		end_of_test;
	end
	initial begin
		arst_n = 1'b0; exec_req = '0; irq_pending = 1'b0; wdt_timeout = 1'b0;
		reg_wr = 1'b0; reg_rd = 1'b0; reg_addr = 4'h0; reg_wdata = 8'h00;
		r(exec_pkg::move_imm_to_acc_op, 8'ha5, 8'ha5, 4'h0, 8'h00);
		r(exec_pkg::decimal_adjust_op, 8'h00, 8'ha5, 4'h5, 8'h05);
		r(exec_pkg::move_imm_to_acc_op, 8'h3c, 8'h3c, 4'h4, 8'h00);
		r(exec_pkg::decimal_adjust_op, 8'h00, 8'h3c, 4'h5, 8'ha2);
		r(exec_pkg::rotate_left_carry_to_acc_op, 8'h81, 8'h03, 4'h4, 8'h00);
		r(exec_pkg::rotate_right_carry_op, 8'h02, 8'h03, 4'h1, 8'h81);
		r(exec_pkg::rotate_left_op, 8'h80, 8'h03, 4'h1, 8'h01);
		r(exec_pkg::rotate_right_to_acc_op, 8'h01, 8'h80, 4'h0, 8'h00);
		r(exec_pkg::rotate_left_to_acc_op, 8'h81, 8'h03, 4'h0, 8'h00);
		r(exec_pkg::rotate_right_op, 8'h01, 8'h03, 4'h1, 8'h80);
		r(exec_pkg::rotate_right_carry_to_acc_op, 8'h03, 8'h01, 4'h4, 8'h00);
		r(exec_pkg::rotate_left_carry_op, 8'h40, 8'h01, 4'h1, 8'h81);
		r(exec_pkg::decrement_to_acc_op, 8'h01, 8'h00, 4'h2, 8'h00);
		r(exec_pkg::increment_to_acc_op, 8'hfe, 8'hff, 4'h0, 8'h00);
		r(exec_pkg::increment_op, 8'hff, 8'hff, 4'h3, 8'h00);
		r(exec_pkg::decrement_op, 8'h00, 8'hff, 4'h1, 8'hff);
		r(exec_pkg::move_mem_to_acc_op, 8'h00, 8'h00, 4'h0, 8'h00);
		r(exec_pkg::or_acc_op, 8'h00, 8'h00, 4'ha, 8'h00);
		r(exec_pkg::or_to_memory_op, 8'h5a, 8'h00, 4'h1, 8'h5a);
		r(exec_pkg::move_acc_to_mem_op, 8'h33, 8'h00, 4'h1, 8'h00);
		r(exec_pkg::no_operation, 8'h77, 8'h00, 4'h0, 8'h00);
		r(exec_pkg::or_acc_op, 8'h81, 8'h81, 4'h0, 8'h00);
		r(exec_pkg::subtract_borrow_op, 8'h81, 8'hff, 4'h0, 8'h00);
		r(exec_pkg::subtract_borrow_op, 8'h0f, 8'hef, 4'h4, 8'h00);
		r(exec_pkg::subtract_borrow_op, 8'hef, 8'h00, 4'h6, 8'h00);
		repeat (2) @(posedge core_clk);
		chk({clk_run, acc, 1'b0, pc_load, busy}, 16'h0800);
		arst_n <= 1'b1;
		$display("test reset done");
		foreach (rows[k]) begin
			issue(rows[k].op, rows[k].m, rows[k].f[3]);
			chk({instr_done, acc, flags.c, flags.z, mem_wr}, {rows[k].a, rows[k].f[2:0]} | 12'h800);
			if (rows[k].f[0]) begin
				chk(mem_wdata, rows[k].d);
				@(posedge core_clk) #1 chk(mem_byte, rows[k].d);
			end
		end
		chk(flags, 6'h07);
		$display("test table done");
		issue(exec_pkg::jump_op, 8'h00, 1'b0);
		chk({pc_load, busy, pc_target}, 16'h35a3);
		@(posedge core_clk);
		#1 chk({busy, instr_done, pc_load, acc}, 11'h200);
		rw(1'b1, exec_pkg::CTRL_ADDR, 8'h00);
		irq_pending <= 1'b1;
		issue(exec_pkg::subroutine_return_imm_op, 8'h3c, 1'b0);
		chk({stack_pop, irq_service, acc}, 10'h23c);
		issue(exec_pkg::interrupt_return_op, 8'h00, 1'b0);
		chk({stack_pop, irq_service, global_interrupt_enable}, 3'h7);
		@(posedge core_clk);
		irq_pending <= 1'b0;
		wdt_timeout <= 1'b1;
		@(posedge core_clk);
		wdt_timeout <= 1'b0;
		#1 chk({pops, watchdog_timeout_flag}, 5'h05);
		$display("test control flow done");
		issue(exec_pkg::power_down_op, 8'h00, 1'b0);
		chk({clk_run, wdt_clear, power_down_flag, watchdog_timeout_flag, busy}, 5'h0d);
		issue(exec_pkg::move_imm_to_acc_op, 8'h99, 1'b0);
		chk({busy, acc}, 9'h13c);
		rw(1'b1, exec_pkg::CTRL_ADDR, 8'h03);
		chk({clk_run, busy, power_down_flag}, 3'h5);
		rw(1'b0, exec_pkg::STATUS_ADDR, 8'h00);
		chk(reg_rdata[7:6], 2'h1);
		rw(1'b0, exec_pkg::CTRL_ADDR, 8'h00);
		chk(reg_rdata, 8'h02);
		rw(1'b0, exec_pkg::ACC_ADDR, 8'h00);
		chk(reg_rdata, 8'h3c);
		rw(1'b0, 4'hc, 8'h00);
		chk(reg_rdata, 8'h00);
		arst_n <= 1'b0;
		#8 chk({power_down_flag, global_interrupt_enable, acc}, 10'h000);
		arst_n <= 1'b1;
		$display("test power-down and reset done");
		end_of_test;
	end
endmodule // tb_top
